// *** rtl/ebc_top.sv ***
// Purpose: external bus control strobes, wait, hold, flag and clock out
// Assumes: pins outside clk_i domain; core request is synchronous
// Notes:   pins are out/oe pairs except clock_mode_o; the pad resolves the wire
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// three stage pin synchroniser
// ------------------------------------------------------------------
module ebc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  always_ff @(posedge clk_i) begin
    s1_ff <= d_i;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end
  // a bit takes stage three once stages two and three agree, else rst_val_i in reset; runs in reset too,
  // so mode pins are really sampled while reset is held
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        q_o[i] <= s3_ff[i];
      end else if (rst_i) begin
        q_o[i] <= rst_val_i[i];
      end
    end
  end
endmodule : ebc_sync

module ebc_top (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // core access port
  input  wire logic               req_valid_i,
  input  wire ebc_pkg::ebc_req_s  req_i,
  output logic                    req_done_o,
  // pins in
  input  wire logic               ready_i,
  input  wire logic               hold_req_n_i,
  input  wire logic               float_all_n_i,
  input  wire logic               clock_mode_pin_a_i,
  input  wire logic               clock_mode_pin_b_i,
  input  wire logic               clock_mode_pin_c_i,
  // pins out
  output ebc_pkg::ebc_bus_s       bus_o,
  output logic                    bus_oe_o,
  output logic                    external_flag_o,
  output logic                    external_flag_oe_o,
  output logic                    bus_grant_ack_n_o,
  output logic                    bus_grant_ack_oe_o,
  output logic                    microstate_done_n_o,
  output logic                    microstate_done_oe_o,
  output logic                    instr_fetch_flag_n_o,
  output logic                    instr_fetch_flag_oe_o,
  output logic                    machine_clock_output_o,
  output logic                    machine_clock_output_oe_o,
  output logic [2:0]              clock_mode_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_READY,
    ST_DONE,
    ST_HOLD
  } ebc_state_e;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [ebc_pkg::SYNC_W-1:0] pin_s;
  ebc_sync #(.W(ebc_pkg::SYNC_W)) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       ({clock_mode_pin_c_i, clock_mode_pin_b_i,
                 clock_mode_pin_a_i, float_all_n_i,
                 hold_req_n_i, ready_i}),
    .rst_val_i (6'h3e),
    .q_o       (pin_s)
  );
  logic       ready_s;
  logic       hold_s;
  logic       float_s;
  logic [2:0] mode_pins_s;
  assign ready_s     = pin_s[0];
  assign hold_s      = ~pin_s[1];
  assign float_s     = ~pin_s[2];
  assign mode_pins_s = pin_s[5:3];

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic [ebc_pkg::CLK_DIV_W-1:0] clk_div_ff;
  logic [ebc_pkg::WAIT_W-1:0]    wait_cfg_ff;
  logic [ebc_pkg::MODE_W-1:0]    clock_mode_ff;
  logic                          flag_ff;
  ebc_state_e                    state_ff;
  logic                          wb_hit;
  logic                          wb_wr;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_hit & ~wb_we_i) begin
        case (wb_adr_i)
          ebc_pkg::BANK_SWITCH_CTRL_OFS: wb_dat_o <= {30'h0, clk_div_ff};
          ebc_pkg::WAIT_STATE_OFS:       wb_dat_o <= {29'h0, wait_cfg_ff};
          ebc_pkg::CLOCK_MODE_OFS:       wb_dat_o <= {29'h0, clock_mode_ff};
          ebc_pkg::STATUS_OFS:           wb_dat_o <= {25'h0, hold_s,
                                             float_s, state_ff, 1'b0,
                                             flag_ff};
          default:                       wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // divisor register: field value n selects divide by n+1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_div_ff <= ebc_pkg::CLK_DIV_RST;
    end else if (wb_wr && wb_adr_i == ebc_pkg::BANK_SWITCH_CTRL_OFS) begin
      clk_div_ff <= wb_dat_i[ebc_pkg::CLK_DIV_LSB +: ebc_pkg::CLK_DIV_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_cfg_ff <= ebc_pkg::WAIT_RST;
    end else if (wb_wr && wb_adr_i == ebc_pkg::WAIT_STATE_OFS) begin
      wait_cfg_ff <= wb_dat_i[ebc_pkg::WAIT_W-1:0];
    end
  end

  // pins tracked every reset cycle, so the last value before release stays
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_mode_ff <= mode_pins_s;
    end else if (wb_wr && wb_adr_i == ebc_pkg::CLOCK_MODE_OFS) begin
      clock_mode_ff <= wb_dat_i[ebc_pkg::MODE_W-1:0];
    end
  end
  assign clock_mode_o = clock_mode_ff;

  // ----------------------------------------------------------------
  // external flag
  // ----------------------------------------------------------------
  logic flag_wr;
  assign flag_wr = wb_wr && wb_adr_i == ebc_pkg::FLAG_CTRL_OFS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b1;
    end else if (flag_wr && (wb_dat_i[ebc_pkg::FLAG_CLR_BIT] ||
                             wb_dat_i[ebc_pkg::FLAG_ST1_BIT])) begin
      flag_ff <= 1'b0;
    end else if (flag_wr && wb_dat_i[ebc_pkg::FLAG_SET_BIT]) begin
      flag_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  ebc_pkg::ebc_req_s          req_ff;
  logic [ebc_pkg::WAIT_W-1:0] wcnt_ff;
  logic                       use_ready;
  assign use_ready = wait_cfg_ff >= ebc_pkg::WAIT_READY_MIN;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      wcnt_ff  <= '0;
      req_ff   <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (hold_s) begin
            state_ff <= ST_HOLD;
          end else if (req_valid_i) begin
            state_ff <= ST_ACCESS;
            req_ff   <= req_i;
            wcnt_ff  <= wait_cfg_ff;
          end
        end
        ST_ACCESS: begin
          if (wcnt_ff != '0) begin
            wcnt_ff <= wcnt_ff - 3'h1;
          end else if (use_ready) begin
            state_ff <= ST_READY;
          end else begin
            state_ff <= ST_DONE;
          end
        end
        // ready low: wait one cycle and look again
        ST_READY: begin
          if (ready_s) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        ST_HOLD: begin
          if (!hold_s) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic in_access;
  assign in_access = state_ff == ST_ACCESS || state_ff == ST_READY;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_o      <= ebc_pkg::BUS_IDLE;
      req_done_o <= 1'b0;
    end else begin
      bus_o      <= ebc_pkg::BUS_IDLE;
      req_done_o <= state_ff == ST_DONE;
      if (in_access) begin
        bus_o.data_sel_n <= req_ff.space != ebc_pkg::EBC_SPACE_DATA;
        bus_o.prog_sel_n <= req_ff.space != ebc_pkg::EBC_SPACE_PROG;
        bus_o.io_sel_n   <= req_ff.space != ebc_pkg::EBC_SPACE_IO;
        bus_o.mem_strobe_n <= req_ff.space == ebc_pkg::EBC_SPACE_IO;
        bus_o.io_strobe_n  <= req_ff.space != ebc_pkg::EBC_SPACE_IO;
        bus_o.read_not_write <= ~req_ff.write;
      end
    end
  end

  // microstate done: low from first wait, high at start of the last
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      microstate_done_n_o <= 1'b1;
    end else if (state_ff == ST_IDLE && req_valid_i && !hold_s &&
                 wait_cfg_ff >= ebc_pkg::WAIT_READY_MIN) begin
      microstate_done_n_o <= 1'b0;
    end else if (state_ff == ST_ACCESS && wcnt_ff == 3'h2) begin
      // looped to ready, the late rise adds one external wait
      microstate_done_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_fetch_flag_n_o <= 1'b1;
      bus_grant_ack_n_o    <= 1'b1;
    end else begin
      instr_fetch_flag_n_o <= ~(in_access & req_ff.fetch);
      bus_grant_ack_n_o    <= state_ff != ST_HOLD;
    end
  end

  // enables out of reset: float pin beats all but the clock output enable, hold floats the bus group; reset drives all six high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_oe_o                  <= 1'b1;
      external_flag_oe_o        <= 1'b1;
      bus_grant_ack_oe_o        <= 1'b1;
      microstate_done_oe_o      <= 1'b1;
      instr_fetch_flag_oe_o     <= 1'b1;
      machine_clock_output_oe_o <= 1'b1;
    end else begin
      bus_oe_o <= ~float_s & ~hold_s & state_ff != ST_HOLD;
      external_flag_oe_o        <= ~float_s;
      bus_grant_ack_oe_o        <= ~float_s;
      microstate_done_oe_o      <= ~float_s;
      instr_fetch_flag_oe_o     <= ~float_s;
      machine_clock_output_oe_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_flag_o <= 1'b1;
    end else begin
      external_flag_o <= flag_ff;
    end
  end

  // ----------------------------------------------------------------
  // clock output divider
  // ----------------------------------------------------------------
  // machine rate is clk_i/2, so a flop output can still reach divide by 1
  logic [ebc_pkg::CLK_DIV_W-1:0] div_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_ff             <= '0;
      machine_clock_output_o <= 1'b0;
    end else if (div_cnt_ff >= clk_div_ff) begin
      div_cnt_ff             <= '0;
      machine_clock_output_o <= ~machine_clock_output_o;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_wr && wb_dat_i[0] && !wb_dat_i[1] && !wb_dat_i[2]
    |=> ##1 external_flag_o)
    else $error("flag not set");
  flag_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_wr && wb_dat_i[2] |=> ##1 !external_flag_o)
    else $error("flag not cleared");
  flag_reset_a: assert property (@(posedge clk_i)
    rst_i |=> external_flag_o && bus_grant_ack_n_o)
    else $error("flag or grant wrong in reset");
  float_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    float_s |=> !external_flag_oe_o && !bus_oe_o && !instr_fetch_flag_oe_o)
    else $error("outputs driven while floated");
  one_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $countones({bus_o.data_sel_n, bus_o.prog_sel_n, bus_o.io_sel_n}) >= 2)
    else $error("two selects low");
  hold_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_grant_ack_n_o |-> !bus_oe_o)
    else $error("bus driven in hold");
  strobe_space_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_o.io_strobe_n |-> !bus_o.io_sel_n && bus_o.mem_strobe_n)
    else $error("io strobe without io space");
  dir_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_o.read_not_write |-> $past(in_access) && req_ff.write)
    else $error("write direction outside write");
  ready_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_READY && !ready_s |=> state_ff == ST_READY)
    else $error("ready low not waited");
  no_ready_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_ACCESS && !use_ready |-> ##[1:8] state_ff == ST_DONE)
    else $error("access without ready not ended");
  msc_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_ACCESS && !use_ready && microstate_done_n_o
    |=> microstate_done_n_o)
    else $error("microstate done active with few waits");
  // looks back, so a divisor write right after a toggle cannot trip it
  clk_div4_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(machine_clock_output_o) && clk_div_ff == 2'h3 &&
    $past(clk_div_ff, 4) == 2'h3
    |-> $past(machine_clock_output_o, 1) ==
        $past(machine_clock_output_o, 4) &&
        $past(machine_clock_output_o, 2) ==
        $past(machine_clock_output_o, 4) &&
        $past(machine_clock_output_o, 3) ==
        $past(machine_clock_output_o, 4))
    else $error("clock output not divided by four");
  hold_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_HOLD);
  ready_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_READY ##1 state_ff == ST_READY ##1 state_ff == ST_DONE);
  float_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
    float_s && in_access);
endmodule : ebc_top
`default_nettype wire

// *** rtl/ebc_pkg.sv ***
// Purpose: constants and types for the external bus control block
// Assumes: 50 MHz clk_i, classic Wishbone register port
// Notes:   register offsets are byte addresses
package ebc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BANK_SWITCH_CTRL_OFS = 8'h00;
  localparam logic [7:0] WAIT_STATE_OFS       = 8'h04;
  localparam logic [7:0] CLOCK_MODE_OFS       = 8'h08;
  localparam logic [7:0] STATUS_OFS           = 8'h0c;
  localparam logic [7:0] FLAG_CTRL_OFS        = 8'h10;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         CLK_DIV_LSB   = 0;
  localparam int         CLK_DIV_W     = 2;
  localparam logic [1:0] CLK_DIV_RST   = 2'h3;
  localparam int         WAIT_W        = 3;
  localparam logic [2:0] WAIT_RST      = 3'h0;
  localparam logic [2:0] WAIT_READY_MIN = 3'h2;
  localparam int         FLAG_SET_BIT  = 0;
  localparam int         FLAG_CLR_BIT  = 1;
  localparam int         FLAG_ST1_BIT  = 2;
  localparam int         MODE_W        = 3;
  localparam int         SYNC_W        = 6;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBC_SPACE_DATA,
    EBC_SPACE_PROG,
    EBC_SPACE_IO
  } ebc_space_e;

  typedef struct packed {
    ebc_space_e space;
    logic       write;
    logic       fetch;
  } ebc_req_s;

  typedef struct packed {
    logic data_sel_n;
    logic prog_sel_n;
    logic io_sel_n;
    logic mem_strobe_n;
    logic io_strobe_n;
    logic read_not_write;
  } ebc_bus_s;

  localparam ebc_bus_s BUS_IDLE = 6'h3f;
endpackage : ebc_pkg

// *** tb/ebc_far_model.sv ***
// Purpose: far side model, external memory or io device and bus master
// Assumes: pins seen on clk_i; a slow device keeps ready low until done
// Notes:   stall_i sets how many select cycles ready stays low
`timescale 1ns/1ps
`default_nettype none

module ebc_far_model (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire ebc_pkg::ebc_bus_s bus_i,
  input  wire logic              bus_oe_i,
  input  wire logic [3:0]        stall_i,
  input  wire logic              want_bus_i,
  output logic                   ready_o,
  output logic                   hold_req_n_o
);
  // ----------------------------------------------------------------
  // ready handshake
  // ----------------------------------------------------------------
  logic [3:0] sel_cnt_ff;
  logic       sel_act;

  // floated selects are not an access, so ready drops low unless stall_i is zero
  assign sel_act = bus_oe_i && (bus_i.data_sel_n == 1'b0 ||
                   bus_i.prog_sel_n == 1'b0 || bus_i.io_sel_n == 1'b0);

  always_ff @(posedge clk_i) begin
    if (rst_i || !sel_act) begin
      sel_cnt_ff <= 4'h0;
    end else if (sel_cnt_ff != 4'hf) begin
      sel_cnt_ff <= sel_cnt_ff + 4'h1;
    end
  end

  // low until the device can finish the access
  // a slow device is not ready between accesses either, so the late
  // synchronised ready never shows a stale high at the sample point
  assign ready_o = sel_act ? (sel_cnt_ff >= stall_i) : (stall_i == 4'h0);

  // ----------------------------------------------------------------
  // bus request from another master
  // ----------------------------------------------------------------
  assign hold_req_n_o = !want_bus_i;
endmodule : ebc_far_model

`default_nettype wire

// *** tb/external_bus_control_signals_tb_top.sv ***
// Purpose: self-checking bench for the external bus control block
// Assumes: classic wishbone master, far model on the bus pins
// Notes:   latencies compared relative, pin sync depth is loose
`timescale 1ns/1ps
`default_nettype none

module external_bus_control_signals_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o;
  logic              wb_ack_o, req_valid_i, req_done_o, ready_i;
  ebc_pkg::ebc_req_s req_i;
  ebc_pkg::ebc_bus_s bus_o;
  logic              hold_req_n_i, float_all_n_i, bus_oe_o;
  logic [2:0]        pins, clock_mode_o;
  logic              flag, flag_oe, gnt_n, gnt_oe, msc_n, msc_oe;
  logic              fet_n, fet_oe, cko, cko_oe, want_bus;
  logic [3:0]        stall_n;
  logic [5:0]        seen_low;
  logic              fetch_seen, msc_seen;
  logic [31:0]       rd;
  int                lat, msc_cnt, error_cnt, compares;

  ebc_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_done_o(req_done_o), .ready_i(ready_i),
    .hold_req_n_i(hold_req_n_i), .float_all_n_i(float_all_n_i),
    .clock_mode_pin_a_i(pins[0]), .clock_mode_pin_b_i(pins[1]),
    .clock_mode_pin_c_i(pins[2]), .bus_o(bus_o), .bus_oe_o(bus_oe_o),
    .external_flag_o(flag), .external_flag_oe_o(flag_oe),
    .bus_grant_ack_n_o(gnt_n), .bus_grant_ack_oe_o(gnt_oe),
    .microstate_done_n_o(msc_n), .microstate_done_oe_o(msc_oe),
    .instr_fetch_flag_n_o(fet_n), .instr_fetch_flag_oe_o(fet_oe),
    .machine_clock_output_o(cko), .machine_clock_output_oe_o(cko_oe),
    .clock_mode_o(clock_mode_o));

  ebc_far_model u_far (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_o), .bus_oe_i(bus_oe_o),
    .stall_i(stall_n), .want_bus_i(want_bus), .ready_o(ready_i),
    .hold_req_n_o(hold_req_n_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic tmo(input string what);
    error_cnt++;
    $display("Error %s expected answer seen timeout", what);
    end_sim();
  endtask : tmo

  task automatic wb_io(input logic we, input logic [7:0] a,
                       input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) tmo("wb ack");
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_io

  // one core access; records which pins went low on the way
  task automatic run_req(input logic [1:0] sp, input logic wr,
                         input logic fe);
    req_i       <= {sp, wr, fe};
    req_valid_i <= 1'b1;
    seen_low = 6'h00;
    fetch_seen = 1'b0;
    msc_seen = 1'b0;
    msc_cnt = 0;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
      if (lat > 200) tmo("req done");
      seen_low = seen_low | ~bus_o;
      if (bus_o !== ebc_pkg::BUS_IDLE) req_valid_i <= 1'b0;
      if (fet_n === 1'b0) fetch_seen = 1'b1;
      if (msc_n === 1'b0) msc_seen = 1'b1;
      if (msc_n === 1'b0) msc_cnt++;
    end while (req_done_o !== 1'b1);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask : run_req

  task automatic clk_period(input int e);
    int rises, first;
    logic prv;
    rises = 0;
    first = 0;
    for (int i = 0; i < 60 && rises < 3; i++) begin
      prv = cko;
      @(posedge clk_i);
      if (prv === 1'b0 && cko === 1'b1) rises++;
      if (prv === 1'b0 && cko === 1'b1 && rises == 2) first = i;
      if (prv === 1'b0 && cko === 1'b1 && rises == 3) lat = i - first;
    end
    if (rises < 3) tmo("clock out edges");
    chk("clock out period", e, lat);
  endtask : clk_period

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_flag();
    wb_io(1'b1, ebc_pkg::FLAG_CTRL_OFS, 32'h2);
    chk("flag after clear", 1'b0, flag);
    wb_io(1'b1, ebc_pkg::FLAG_CTRL_OFS, 32'h1);
    chk("flag after set", 1'b1, flag);
    wb_io(1'b1, ebc_pkg::FLAG_CTRL_OFS, 32'h4);
    chk("flag after load", 1'b0, flag);
    $display("test flag done");
  endtask : t_flag

  task automatic t_access();
    logic [1:0] sp;
    logic       wr, fe;
    logic [5:0] e;
    for (int i = 0; i < 6; i++) begin
      sp = 2'(i / 2);
      wr = i[0];
      fe = (sp == 2'h1) && !wr;
      e = (sp == 2'h0) ? 6'h24 : (sp == 2'h1) ? 6'h14 : 6'h0a;
      run_req(sp, wr, fe);
      chk("pins low", e | {5'h00, wr}, seen_low);
      chk("fetch flag", fe, fetch_seen);
      chk("msc no waits", 1'b0, msc_seen);
      chk("bus idle", ebc_pkg::BUS_IDLE, bus_o);
    end
    $display("test access done");
  endtask : t_access

  task automatic t_wait();
    int l0, m0;
    for (int n = 1; n < 4; n++) begin
      stall_n <= 4'h0;
      wb_io(1'b1, ebc_pkg::WAIT_STATE_OFS, 32'(n));
      run_req(2'h0, 1'b0, 1'b0);
      l0 = lat;
      m0 = msc_cnt;
      stall_n <= 4'hc;
      run_req(2'h1, 1'b1, 1'b0);
      chk("ready stalls", n >= 2, lat > l0);
      chk("msc active", n >= 2, msc_seen);
      chk("msc length", m0, msc_cnt);
      chk("msc cycles", (n >= 2) ? n - 1 : 0, msc_cnt);
      chk("msc high at end", 1'b1, msc_n);
    end
    stall_n <= 4'h0;
    wb_io(1'b1, ebc_pkg::WAIT_STATE_OFS, 32'h0);
    $display("test wait done");
  endtask : t_wait

  task automatic t_hold();
    int n, dn;
    n = 0;
    dn = 0;
    want_bus <= 1'b1;
    while (gnt_n !== 1'b0) begin
      @(posedge clk_i);
      n++;
      if (n > 50) tmo("grant");
    end
    chk("bus float in hold", 1'b0, bus_oe_o);
    chk("grant driven", 1'b1, gnt_oe);
    wb_io(1'b0, ebc_pkg::STATUS_OFS, 32'h0);
    chk("status in hold", 32'h50, rd);
    req_valid_i <= 1'b1;
    repeat (10) begin
      @(posedge clk_i);
      if (req_done_o !== 1'b0) dn++;
    end
    chk("access in hold", 0, dn);
    req_valid_i <= 1'b0;
    want_bus <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("grant released", 2'h3, {gnt_n, bus_oe_o});
    run_req(2'h2, 1'b1, 1'b0);
    chk("pins after hold", 6'h0b, seen_low);
    $display("test hold done");
  endtask : t_hold

  task automatic t_float();
    float_all_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("enables floated", 5'h00,
        {bus_oe_o, flag_oe, gnt_oe, msc_oe, fet_oe});
    chk("clock out oe", 1'b1, cko_oe);
    float_all_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("enables back", 5'h1f,
        {bus_oe_o, flag_oe, gnt_oe, msc_oe, fet_oe});
    $display("test float done");
  endtask : t_float

  task automatic t_clk();
    for (int f = 0; f < 4; f++) begin
      wb_io(1'b1, ebc_pkg::BANK_SWITCH_CTRL_OFS, 32'(f));
      clk_period(2 * (f + 1));
    end
    $display("test clock divider done");
  endtask : t_clk

  task automatic t_mode();
    pins <= 3'h2;
    repeat (8) @(posedge clk_i);
    chk("mode kept", 3'h5, clock_mode_o);
    wb_io(1'b1, ebc_pkg::CLOCK_MODE_OFS, 32'h3);
    chk("mode written", 3'h3, clock_mode_o);
    wb_io(1'b0, ebc_pkg::CLOCK_MODE_OFS, 32'h0);
    chk("mode read", 32'h3, rd);
    $display("test clock mode done");
  endtask : t_mode

  // second reset mid-run, after flag cleared and clock mode written
  task automatic t_reset();
    wb_io(1'b1, ebc_pkg::FLAG_CTRL_OFS, 32'h2);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("flag in reset", 1'b1, flag);
    chk("grant in reset", 2'h3, {gnt_n, gnt_oe});
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("mode sampled", 3'h2, clock_mode_o);
    clk_period(8);
    $display("test reset done");
  endtask : t_reset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i} = 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0f_00000000;
    req_i = '0;
    float_all_n_i = 1'b1;
    pins = 3'h5;
    want_bus = 1'b0;
    stall_n = 4'h0;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clk_i);
    chk("flag at reset", 1'b1, flag);
    chk("bus at reset", ebc_pkg::BUS_IDLE, bus_o);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("mode at release", 3'h5, clock_mode_o);
    clk_period(8);
    t_flag();
    t_access();
    t_wait();
    t_hold();
    t_float();
    t_clk();
    t_mode();
    t_reset();
    end_sim();
  end
endmodule : external_bus_control_signals_tb_top

`default_nettype wire
